// [rtl/eveq_pkg.sv]
package eveq_pkg;
   // ****************************************************************
   // Event bit positions and weights
   // ****************************************************************
   localparam int EV_OPC = 0;
   localparam int EV_RQC = 1;
   localparam int EV_QYE = 2;
   localparam int EV_DDE = 3;
   localparam int EV_EXE = 4;
   localparam int EV_CME = 5;
   localparam int EV_URQ = 6;
   localparam int EV_PON = 7;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h80;
   localparam int STB_ESB_BIT = 5;
   // ****************************************************************
   // Error queue
   // ****************************************************************
   localparam int QDEPTH = 30;
   localparam int QPTR_W = 5;
   localparam int QCNT_W = 6;
   localparam logic signed [15:0] ERR_NONE = 16'sh0000;
   localparam logic signed [15:0] ERR_CMD = -16'sd100;
   localparam logic signed [15:0] ERR_BADCHAR = -16'sd101;
   localparam logic signed [15:0] ERR_SYNTAX = -16'sd102;
   localparam logic signed [15:0] ERR_SEP = -16'sd103;
   localparam logic signed [15:0] ERR_DTYPE = -16'sd104;
   localparam logic signed [15:0] ERR_XPARAM = -16'sd108;
   localparam logic signed [15:0] ERR_MPARAM = -16'sd109;
   localparam logic signed [15:0] ERR_NUMNA = -16'sd128;
   localparam logic signed [15:0] ERR_SUFFIX = -16'sd131;
   localparam logic signed [15:0] ERR_CHARNA = -16'sd148;
   localparam logic signed [15:0] ERR_EXEC = -16'sd200;
   localparam logic signed [15:0] ERR_CONFLICT = -16'sd221;
   localparam logic signed [15:0] ERR_RANGE = -16'sd222;
   localparam logic signed [15:0] ERR_ILLEGAL = -16'sd224;
   localparam logic signed [15:0] ERR_DEVICE = -16'sd300;
   localparam logic signed [15:0] ERR_MEMORY = -16'sd311;
   localparam logic signed [15:0] ERR_OVERFLOW = -16'sd350;
   localparam logic signed [15:0] ERR_INTERRUPTED = -16'sd410;
   localparam int TEXT_MAX = 80;
   // ****************************************************************
   // Setting conflict limits
   // ****************************************************************
   localparam logic [15:0] TIMING_SUM_MAX = 16'd100;
   localparam logic [15:0] LEVEL_MAX = 16'd16;
   // ****************************************************************
   // Fault kinds reported by the parser and setting logic
   // ****************************************************************
   typedef enum logic [3:0] {
      F_GENERIC, F_BADCHAR, F_SYNTAX, F_SEP, F_DTYPE, F_XPARAM,
      F_MPARAM, F_NUMNA, F_SUFFIX, F_CHARNA, F_EXEC, F_RANGE,
      F_ILLEGAL, F_DEVICE, F_MEMORY, F_SEP_UNKNOWN
   } eveq_fault_t;
endpackage : eveq_pkg

// [rtl/eveq_top.sv]
// Summary of operation
// - An 8-bit enable mask picks which latched events feed the summary.
// - Mask query returns the weighted mask value and leaves it unchanged.
// - Mask write stores the given weight value; zero clears every bit.
// - Bit weights 1 to 128: opc, rqc, qye, dde, exe, cme, urq, pon.
// - Every invalid command appends an error entry to the error queue until it holds 30 entries.
// - Each error read pops exactly one entry, oldest first.
// - Reading an empty queue returns code 0 with no-error text.
// - Past 30 errors the newest slot becomes -350; later errors drop.
// - Queue empties at power-up and clear-status; reset command keeps it.
// - Entries are a signed code plus quoted text of at most 80 chars.
// - Syntax faults map to codes -100 to -148 as listed.
// - An unidentified separator fault may be reported as -100.
// - Execution faults map to -200, -221, -222 and -224.
// - Timing sum over 100 or amplitude/2 plus offset magnitude over 16 conflicts.
// - Filter with built-in sine, or burst with sequence, is a conflict.
// - Continuous with single advance, or triggered with auto, conflicts.
// - Device faults are -300 generic and -311 internal memory.
// - A response over unread output logs -410 and keeps old data.
// - The output buffer empties at power-up and on device clear.
// - Summary bit, weight 32, is set while any enabled event is latched.
// - The event latch clears on its query and clear-status; power-on leaves only pon set.
`timescale 1ns/10ps
`default_nettype none
module eveq_top
(
   // Clock, enable and reset.
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_sys_rst,
   // Mask access.
   input wire logic i_mask_wr,
   input wire logic [7:0] i_mask_wdata,
   output logic [7:0] o_event_enable_mask,
   // Event latch access and event sources.
   input wire logic i_latch_rd,
   input wire logic i_op_complete,
   input wire logic i_user_request,
   output logic [7:0] o_standard_event_latch,
   output logic o_event_summary_bit,
   output logic [7:0] o_stb_esb,
   // Commands.
   input wire logic i_clear_status,
   input wire logic i_reset_cmd,
   input wire logic i_device_clear,
   // Parser faults.
   input wire logic i_fault,
   input wire logic [3:0] i_fault_kind,
   // Setting checks.
   input wire logic i_check,
   input wire logic [15:0] i_timing_sum,
   input wire logic [15:0] i_amplitude,
   input wire logic signed [15:0] i_offset,
   input wire logic i_filter_on,
   input wire logic i_sine_sel,
   input wire logic i_burst_on,
   input wire logic i_seq_on,
   input wire logic i_to_continuous,
   input wire logic i_to_triggered,
   input wire logic i_single_adv,
   input wire logic i_auto_adv,
   // Response buffer.
   input wire logic i_resp_push,
   input wire logic [15:0] i_resp_data,
   input wire logic i_resp_read,
   output logic o_resp_valid,
   output logic [15:0] o_resp_data,
   // Error read.
   input wire logic i_err_rd,
   output logic signed [15:0] o_err_code,
   output logic o_err_valid,
   output logic [5:0] o_err_count
);
   // ****************************************************************
   // Error source encoding
   // ****************************************************************
   logic signed [15:0] fault_code;
   logic signed [15:0] check_code;
   logic [15:0] abs_offset;
   logic conflict;
   logic resp_clash;
   logic push;
   logic signed [15:0] push_code;
   always_comb
   begin
      // A separator fault without a known separator reports generic.
      case (eveq_pkg::eveq_fault_t'(i_fault_kind))
         eveq_pkg::F_GENERIC: fault_code = eveq_pkg::ERR_CMD;
         eveq_pkg::F_BADCHAR: fault_code = eveq_pkg::ERR_BADCHAR;
         eveq_pkg::F_SYNTAX: fault_code = eveq_pkg::ERR_SYNTAX;
         eveq_pkg::F_SEP: fault_code = eveq_pkg::ERR_SEP;
         eveq_pkg::F_SEP_UNKNOWN: fault_code = eveq_pkg::ERR_CMD;
         eveq_pkg::F_DTYPE: fault_code = eveq_pkg::ERR_DTYPE;
         eveq_pkg::F_XPARAM: fault_code = eveq_pkg::ERR_XPARAM;
         eveq_pkg::F_MPARAM: fault_code = eveq_pkg::ERR_MPARAM;
         eveq_pkg::F_NUMNA: fault_code = eveq_pkg::ERR_NUMNA;
         eveq_pkg::F_SUFFIX: fault_code = eveq_pkg::ERR_SUFFIX;
         eveq_pkg::F_CHARNA: fault_code = eveq_pkg::ERR_CHARNA;
         eveq_pkg::F_EXEC: fault_code = eveq_pkg::ERR_EXEC;
         eveq_pkg::F_RANGE: fault_code = eveq_pkg::ERR_RANGE;
         eveq_pkg::F_ILLEGAL: fault_code = eveq_pkg::ERR_ILLEGAL;
         eveq_pkg::F_DEVICE: fault_code = eveq_pkg::ERR_DEVICE;
         eveq_pkg::F_MEMORY: fault_code = eveq_pkg::ERR_MEMORY;
         default: fault_code = eveq_pkg::ERR_CMD;
      endcase
   end
   assign abs_offset = i_offset[15] ? 16'(-i_offset) : 16'(i_offset);
   // Twice the limit is compared against amplitude plus twice the offset magnitude,
   // so that half an odd amplitude is not lost to truncation.
   // The sum is kept two bits wider so that large inputs cannot wrap.
   assign conflict = i_check &&
      ((i_timing_sum > eveq_pkg::TIMING_SUM_MAX) ||
       ({2'b00, i_amplitude} + {1'b0, abs_offset, 1'b0} >
        {1'b0, eveq_pkg::LEVEL_MAX, 1'b0}) ||
       (i_filter_on && i_sine_sel) || (i_burst_on && i_seq_on) ||
       (i_to_continuous && i_single_adv) ||
       (i_to_triggered && i_auto_adv));
   assign check_code = eveq_pkg::ERR_CONFLICT;
   assign resp_clash = i_resp_push && o_resp_valid && !i_resp_read;
   // Parser faults take priority; a clash in the same cycle is dropped.
   assign push = i_fault || conflict || resp_clash;
   assign push_code = i_fault ? fault_code :
                      conflict ? check_code :
                      eveq_pkg::ERR_INTERRUPTED;
   // ****************************************************************
   // Enable mask
   // ****************************************************************
   logic [7:0] mask;
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         mask <= eveq_pkg::MASK_RESET;
      else if (i_ce && i_mask_wr)
         mask <= i_mask_wdata;
   end
   assign o_event_enable_mask = mask;
   // ****************************************************************
   // Standard event latch
   // ****************************************************************
   logic [7:0] latch;
   logic [7:0] ev_set;
   always_comb
   begin
      ev_set = 8'h00;
      ev_set[eveq_pkg::EV_OPC] = i_op_complete;
      ev_set[eveq_pkg::EV_URQ] = i_user_request;
      if (push)
      begin
         case (push_code / 16'sd100)
            -16'sd1: ev_set[eveq_pkg::EV_CME] = 1'b1;
            -16'sd2: ev_set[eveq_pkg::EV_EXE] = 1'b1;
            -16'sd3: ev_set[eveq_pkg::EV_DDE] = 1'b1;
            -16'sd4: ev_set[eveq_pkg::EV_QYE] = 1'b1;
            default: ev_set = ev_set;
         endcase
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         latch <= eveq_pkg::LATCH_RESET;
      else if (i_ce)
      begin
         // New events win over a clear in the same cycle.
         if (i_latch_rd || i_clear_status)
            latch <= ev_set;
         else
            latch <= latch | ev_set;
      end
   end
   assign o_standard_event_latch = latch;
   assign o_event_summary_bit = |(latch & mask);
   assign o_stb_esb = {2'b00, o_event_summary_bit, 5'b0_0000};
   // ****************************************************************
   // Error queue
   // ****************************************************************
   logic signed [15:0] q_mem [eveq_pkg::QDEPTH];
   logic [4:0] rd_ptr;
   logic [4:0] wr_ptr;
   logic [5:0] count;
   logic q_full;
   logic do_pop;
   logic do_push;
   logic [4:0] last_ptr;
   assign q_full = (count == 6'(eveq_pkg::QDEPTH));
   assign do_pop = i_err_rd && (count != 6'd0);
   assign do_push = push && !q_full;
   assign last_ptr = (wr_ptr == 5'd0) ? 5'(eveq_pkg::QDEPTH - 1) :
                     wr_ptr - 5'd1;
   function automatic logic [4:0] inc_ptr(input logic [4:0] p);
      inc_ptr = (p == 5'(eveq_pkg::QDEPTH - 1)) ? 5'd0 : p + 5'd1;
   endfunction : inc_ptr
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || (i_ce && i_clear_status))
      begin
         rd_ptr <= 5'd0;
         wr_ptr <= 5'd0;
         count <= 6'd0;
      end
      else if (i_ce)
      begin
         // The reset command is deliberately not a term here.
         if (do_pop)
            rd_ptr <= inc_ptr(rd_ptr);
         if (do_push)
            wr_ptr <= inc_ptr(wr_ptr);
         if (do_push && !do_pop)
            count <= count + 6'd1;
         else if (do_pop && !do_push)
            count <= count - 6'd1;
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (i_ce && do_push)
         q_mem[wr_ptr] <= push_code;
      else if (i_ce && push && q_full && !do_pop)
         q_mem[last_ptr] <= eveq_pkg::ERR_OVERFLOW;
   end
   // Popped entry is registered; the text table lives with the formatter.
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_err_code <= eveq_pkg::ERR_NONE;
         o_err_valid <= 1'b0;
      end
      else if (i_ce)
      begin
         o_err_valid <= i_err_rd;
         if (i_err_rd)
            o_err_code <= do_pop ? q_mem[rd_ptr] :
                          eveq_pkg::ERR_NONE;
      end
   end
   assign o_err_count = count;
   // ****************************************************************
   // Response output buffer
   // ****************************************************************
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || (i_ce && i_device_clear))
      begin
         o_resp_valid <= 1'b0;
         o_resp_data <= 16'h0000;
      end
      else if (i_ce)
      begin
         if (i_resp_push && (!o_resp_valid || i_resp_read))
         begin
            o_resp_valid <= 1'b1;
            o_resp_data <= i_resp_data;
         end
         else if (i_resp_read)
            o_resp_valid <= 1'b0;
      end
   end
   // ****************************************************************
   // Checks
   // ****************************************************************
   a_pop_order: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && do_pop && !i_clear_status
      |=> o_err_code == $past(q_mem[rd_ptr]))
      else $error("popped code not oldest");
   a_empty_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_err_rd && count == 6'd0
      |=> o_err_valid && o_err_code == 16'sd0)
      else $error("empty read not zero");
   a_queue_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      count <= 6'(eveq_pkg::QDEPTH))
      else $error("queue count above thirty");
   a_overflow_mark: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && push && q_full && !do_pop && !i_clear_status
      |=> q_mem[$past(last_ptr)] == eveq_pkg::ERR_OVERFLOW)
      else $error("overflow mark missing");
   a_ce_freeze: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_ce |=> count == $past(count) && rd_ptr == $past(rd_ptr))
      else $error("queue moved while frozen");
   a_err_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_err_rd |=> o_err_valid)
      else $error("error read not answered");
   a_clr_empties: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_clear_status |=> count == 6'd0)
      else $error("clear-status left entries");
   a_rst_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_reset_cmd && !i_clear_status && !push && !i_err_rd
      |=> count == $past(count))
      else $error("reset command altered queue");
   a_summary_or: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_stb_esb[eveq_pkg::STB_ESB_BIT] ==
      |(o_standard_event_latch & o_event_enable_mask))
      else $error("summary bit wrong");
   a_mask_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_event_enable_mask == 8'h00 |-> !o_event_summary_bit)
      else $error("summary set with no mask");
   a_latch_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_latch_rd && !i_op_complete && !i_user_request && !push
      |=> o_standard_event_latch == 8'h00)
      else $error("event latch not cleared");
   a_set_wins: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_clear_status && i_op_complete
      |=> o_standard_event_latch[eveq_pkg::EV_OPC])
      else $error("event lost to clear");
   a_exe_event: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && conflict && !i_fault
      |=> o_standard_event_latch[eveq_pkg::EV_EXE])
      else $error("execution error not latched");
   a_resp_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_resp_push && !o_resp_valid && !i_device_clear
      |=> o_resp_valid && o_resp_data == $past(i_resp_data))
      else $error("response not stored");
   a_clash_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && resp_clash && !i_device_clear
      |=> o_resp_valid && o_resp_data == $past(o_resp_data))
      else $error("held response overwritten");
   a_devclr_empty: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_device_clear |=> !o_resp_valid)
      else $error("device clear kept data");
   a_mask_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_mask_wr |=> o_event_enable_mask == $past(i_mask_wdata))
      else $error("mask write lost");
   a_cmd_event: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_fault && i_fault_kind == 4'd2 |=> o_standard_event_latch[5])
      else $error("command error not latched");
endmodule : eveq_top
`default_nettype wire

// [verif/eveq_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Remote controller: mask writes and error reads
// ****************************************************************
module eveq_ctrl_model
(
   // Clock.
   input wire logic i_clk,
   // Mask access.
   output logic o_mask_wr,
   output logic [7:0] o_mask_wdata,
   // Error read.
   output logic o_err_rd,
   input wire logic i_err_valid,
   input wire logic signed [15:0] i_err_code
);
   initial
   begin
      o_mask_wr = 1'b0;
      o_mask_wdata = 8'h00;
      o_err_rd = 1'b0;
   end
   // The mask goes as its bit-weight value; zero clears every bit.
   task automatic write_mask(input logic [7:0] v);
      @(negedge i_clk);
      o_mask_wr = 1'b1;
      o_mask_wdata = v;
      @(negedge i_clk);
      o_mask_wr = 1'b0;
      o_mask_wdata = ~v;
   endtask : write_mask
   // A slow controller idles gap cycles, so reads are not always dense.
   task automatic read_err(input int gap, output logic [15:0] c);
      int n;
      c = 16'h7FFF;
      repeat (gap) @(negedge i_clk);
      @(negedge i_clk);
      o_err_rd = 1'b1;
      @(negedge i_clk);
      o_err_rd = 1'b0;
      for (n = 0; n < 4; n++)
      begin
         if (i_err_valid === 1'b1)
         begin
            c = i_err_code;
            break;
         end
         @(negedge i_clk);
      end
   endtask : read_err
endmodule : eveq_ctrl_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam logic [9:0] LRD = 10'h001, OPU = 10'h006, CLS = 10'h008,
      RST = 10'h010, DCL = 10'h020, FLT = 10'h040, CHK = 10'h080,
      PSH = 10'h100, RRD = 10'h200;
   logic i_clk, i_sys_rst, mwr, erd;
   logic [9:0] cmd;
   logic [3:0] kind;
   logic [7:0] st, mwd, lat, m;
   logic [15:0] ts, amp, ofs, rdat, got;
   logic [31:0] rnd;
   wire logic [7:0] mask, latch, stb;
   wire logic event_summary_bit, rvalid, evalid;
   wire logic [15:0] rdata, ecode;
   wire logic [5:0] cnt;
   int failures = 0, checks_done = 0, k;
   int q [$];
   int codes [16] = '{-100, -101, -102, -103, -104, -108, -109, -128,
      -131, -148, -200, -222, -224, -300, -311, -100};
   logic [7:0] pats [8] = '{8'h03, 8'h0C, 8'h50, 8'hA0, 8'h01, 8'h08,
      8'h10, 8'h60};
   eveq_top i_dut (.i_clk(i_clk), .i_ce(1'b1), .i_sys_rst(i_sys_rst),
      .i_mask_wr(mwr), .i_mask_wdata(mwd), .o_event_enable_mask(mask),
      .i_latch_rd(cmd[0]), .i_op_complete(cmd[1]),
      .i_user_request(cmd[2]), .o_standard_event_latch(latch),
      .o_event_summary_bit(event_summary_bit), .o_stb_esb(stb),
      .i_clear_status(cmd[3]), .i_reset_cmd(cmd[4]),
      .i_device_clear(cmd[5]), .i_fault(cmd[6]), .i_fault_kind(kind),
      .i_check(cmd[7]), .i_timing_sum(ts), .i_amplitude(amp),
      .i_offset(ofs), .i_filter_on(st[0]), .i_sine_sel(st[1]),
      .i_burst_on(st[2]), .i_seq_on(st[3]), .i_to_continuous(st[4]),
      .i_to_triggered(st[5]), .i_single_adv(st[6]), .i_auto_adv(st[7]),
      .i_resp_push(cmd[8]), .i_resp_data(rdat), .i_resp_read(cmd[9]),
      .o_resp_valid(rvalid), .o_resp_data(rdata), .i_err_rd(erd),
      .o_err_code(ecode), .o_err_valid(evalid), .o_err_count(cnt));
   eveq_ctrl_model i_ctrl (.i_clk(i_clk), .o_mask_wr(mwr),
      .o_mask_wdata(mwd), .o_err_rd(erd), .i_err_valid(evalid),
      .i_err_code(ecode));
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // ****************************************************************
   // Helpers and reference model
   // ****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'hA300_0000 : 32'h0000_0000);
   endfunction : lfsr
   task automatic tick;
      @(negedge i_clk);
   endtask : tick
   // Strobes drop for a cycle between pulses so none is set twice at once.
   task automatic pulse(input logic [9:0] p);
      cmd = p;
      tick;
      cmd = 10'h000;
      tick;
   endtask : pulse
   task automatic chk(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic mpush(input int c);
      if (q.size() < 30)
         q.push_back(c);
      else
         q[29] = -350;
      lat[6 - (-c) / 100] = 1'b1;
   endtask : mpush
   task automatic chkcnt;
      chk("err count", 16'(cnt), 16'(q.size()));
   endtask : chkcnt
   task automatic fault(input int f);
      kind = 4'(f);
      pulse(FLT);
      mpush(codes[f]);
      chkcnt;
   endtask : fault
   task automatic cfg(input logic [7:0] s, input int t, a, o, cf);
      st = s;
      ts = 16'(t);
      amp = 16'(a);
      ofs = 16'(o);
      pulse(CHK);
      if (cf != 0)
         mpush(-221);
      chkcnt;
   endtask : cfg
   task automatic drain;
      while (q.size() > 0)
      begin
         i_ctrl.read_err(q.size() % 3, got);
         chk("err code", got, 16'(q.pop_front()));
         chkcnt;
      end
      i_ctrl.read_err(0, got);
      chk("empty code", got, 16'h0000);
   endtask : drain
   task automatic results;
      if (failures == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   initial
   begin
      repeat (20000) @(posedge i_clk);
      failures++;
      results;
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      {cmd, kind, st, ts, amp, ofs, rdat} = '0;
      rnd = 32'h0001_611D;
      lat = 8'h41;
      i_sys_rst = 1'b1;
      repeat (4) tick;
      i_sys_rst = 1'b0;
      chk("mask rst", 16'(mask), 16'h0000);
      chk("latch rst", 16'(latch), 16'h0080);
      chk("count rst", 16'(cnt), 16'h0000);
      chk("resp rst", 16'(rvalid), 16'h0000);
      pulse(LRD);
      pulse(OPU);
      chk("latch", 16'(latch), 16'(lat));
      for (k = 0; k < 6; k++)
      begin
         rnd = lfsr(rnd);
         m = (k == 5) ? 8'h00 : rnd[7:0];
         i_ctrl.write_mask(m);
         tick;
         chk("mask", 16'(mask), 16'(m));
         chk("esb", 16'(event_summary_bit), 16'(|(m & lat)));
         chk("stb", 16'(stb), 16'({|(m & lat), 5'h00}));
      end
      pulse(CLS);
      lat = 8'h00;
      for (k = 0; k < 16; k++)
      begin
         fault(k);
         chk("latch", 16'(latch), 16'(lat));
      end
      drain;
      for (k = 0; k < 8; k++)
         cfg(pats[k], 0, 0, 0, k < 4);
      cfg(8'h00, 101, 0, 0, 1);
      cfg(8'h00, 100, 0, 0, 0);
      cfg(8'h00, 0, 9, -12, 1);
      cfg(8'h00, 0, 8, -12, 0);
      drain;
      rnd = lfsr(rnd);
      rdat = rnd[15:0];
      pulse(PSH);
      chk("resp data", rdata, rnd[15:0]);
      rdat = ~rnd[15:0];
      pulse(PSH);
      mpush(-410);
      chk("resp kept", rdata, rnd[15:0]);
      chkcnt;
      chk("latch", 16'(latch), 16'(lat));
      pulse(RRD);
      chk("resp read", 16'(rvalid), 16'h0000);
      pulse(PSH);
      chk("resp held", 16'(rvalid), 16'h0001);
      pulse(DCL);
      chk("resp clr", 16'(rvalid), 16'h0000);
      drain;
      for (k = 0; k < 5; k++)
         fault(k);
      pulse(RST);
      chkcnt;
      pulse(CLS);
      q.delete();
      lat = 8'h00;
      chkcnt;
      drain;
      for (k = 0; k < 32; k++)
         fault(2);
      drain;
      results;
   end
endmodule : testbench
`default_nettype wire
